// *** hw/ubev_pkg.sv ***
package ubev_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_NS = 50;
  localparam int RST_MIN_NS = 2500;
  localparam int SUSP_MS = 3;
  localparam int OSC_STOP_MS = 2;
  localparam int RESUME_SE0_NS = 1344;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SUSP_CYC = SUSP_MS * (CLK_HZ / 1000);
  localparam int OSC_STOP_CYC = OSC_STOP_MS * (CLK_HZ / 1000);
  localparam int RESUME_MIN_CYC = RESUME_SE0_NS / 2 / CLK_NS;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_EVT_STATUS = 4'h0;
  localparam logic [3:0] ADDR_EVT_ENABLE = 4'h1;
  localparam logic [3:0] ADDR_EVT_CLEAR = 4'h2;
  localparam logic [3:0] ADDR_STANDBY = 4'h3;
  localparam logic [3:0] ADDR_OSC_TEST = 4'h4;
  localparam logic [3:0] ADDR_DMA_CTRL0 = 4'h5;
  localparam logic [3:0] ADDR_DMA_CTRL1 = 4'h6;
  localparam logic [3:0] ADDR_DMA_INTV0 = 4'h7;
  localparam logic [3:0] ADDR_DMA_INTV1 = 4'h8;
  localparam logic [3:0] ADDR_POWER = 4'h9;

  // event bits
  localparam int EV_SOF = 0;
  localparam int EV_RST_ON = 1;
  localparam int EV_RST_OFF = 2;
  localparam int EV_SUSPEND = 3;
  localparam int EV_AWAKE = 4;
  localparam int EV_NUM = 5;

  // field positions
  localparam int OSC_STOP_SEL_BIT = 3;
  localparam int OSC_TEST_PD_BIT = 2;
  localparam int OSC_TEST_ZERO_BIT = 1;
  localparam int DMA_EN_BIT = 0;
  localparam int DMA_MODE_BIT = 1;
  localparam int DMA_EP_LSB = 2;
  localparam int DMA_EP_W = 3;

  localparam logic [7:0] REG_RESET = 8'h00;

  // line states, {dplus, dminus}
  typedef enum logic [1:0] {
    LINE_SE0 = 2'b00,
    LINE_K = 2'b01,
    LINE_J = 2'b10,
    LINE_SE1 = 2'b11
  } ubev_line_type;

  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_BUSY = 3'b010,
    DMA_GAP = 3'b100
  } ubev_dma_type;
endpackage : ubev_pkg

// *** hw/ubev_dma_chan.sv ***
`timescale 1ns/1ps
module ubev_dma_chan
  import ubev_pkg::*;
#(
  parameter int INTV_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic singleMode,
  input wire logic [INTV_W-1:0] gapCycles,
  input wire logic packetReady,
  input wire logic byteAck,
  input wire logic packetDone,
  output logic dmaRequestLine
);
  initial begin
    if (INTV_W < 1) $error("INTV_W too small");
  end

  ubev_dma_type state;
  ubev_dma_type next_state;
  logic [INTV_W-1:0] gapCount;

  always_comb begin
    next_state = state;
    case (state)
      DMA_IDLE: if (enable && packetReady) next_state = DMA_BUSY;
      DMA_BUSY: begin
        if (packetDone || !enable) next_state = DMA_IDLE;
        else if (singleMode && byteAck) next_state = DMA_GAP;
      end
      DMA_GAP: if (!enable) next_state = DMA_IDLE;
        else if (gapCount == '0) next_state = DMA_BUSY;
      default: next_state = DMA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) state <= DMA_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gapCount <= '0;
    else if (state == DMA_BUSY) gapCount <= gapCycles;
    else if (gapCount != '0) gapCount <= gapCount - 1'b1;
  end

  // request held through the whole packet in demand mode
  assign dmaRequestLine = (state == DMA_BUSY);
endmodule : ubev_dma_chan

// *** hw/ubev_bus_events.sv ***
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
// Operation
// - SOF detected sets flag and interrupt
// - flags sticky until firmware writes one
// - SE0 2.5 us raises reset-assert
// - J after long SE0 raises reset-release
// - idle 3 ms raises suspend
// - further 2 ms idle stops oscillation
// - SE0 after K raises awake
// - byte DMA on endpoints 1,2,4,5
// - two DMA channels with control, interval
// - each channel demand or single mode
// - demand holds request for whole packet
// - single drops request after each unit
// - suspend stops PLL, enters power-down
// - oscillator stops if selected and CPU slow
// - resume restarts oscillator, PLL, exits power-down
// - test bit2=1, bit1=0 forces power-down
module ubev_bus_events
  import ubev_pkg::*;
#(
  parameter int SUSP_CYCLES = SUSP_CYC,
  parameter int OSC_STOP_CYCLES = OSC_STOP_CYC,
  parameter int INTV_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dPlus,
  input wire logic dMinus,
  input wire logic sofSeen,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic irq,
  input wire logic [5:0] epPacketReady,
  input wire logic [1:0] dmaByteAck,
  input wire logic [1:0] dmaPacketDone,
  output logic [1:0] dmaRequestLine,
  output logic [1:0][DMA_EP_W-1:0] dmaEndpoint,
  input wire logic cpuStopOrSub,
  output logic pllEnable,
  output logic oscEnable,
  output logic usbOscRun,
  output logic powerDown
);
  initial begin
    if (SUSP_CYCLES < 2 || OSC_STOP_CYCLES < 1) $error("bad timing parameters");
    if (INTV_W < 1 || INTV_W > 8) $error("INTV_W must be 1..8");
  end

  localparam int CW = $clog2(SUSP_CYCLES + OSC_STOP_CYCLES + 2);

  // ---------------------------------------------------------------
  // line monitor
  // ---------------------------------------------------------------
  logic [1:0] line;
  logic [1:0] prevLine;
  logic [CW-1:0] stateCount;
  logic longSe0;
  logic afterK;
  logic suspended;
  logic [EV_NUM-1:0] evPulse;

  assign line = {dPlus, dMinus};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) prevLine <= LINE_J;
    else prevLine <= line;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) stateCount <= '0;
    else if (line != prevLine) stateCount <= '0;
    else if (stateCount != '1) stateCount <= stateCount + 1'b1;
  end

  // se0 entered right after K is the resume candidate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) afterK <= 1'b0;
    else if (line != prevLine) afterK <= (prevLine == LINE_K) && (line == LINE_SE0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) longSe0 <= 1'b0;
    else if (line == LINE_SE0 && stateCount == CW'(RST_MIN_CYC - 1)) longSe0 <= 1'b1;
    else if (line != LINE_SE0) longSe0 <= 1'b0;
  end

  always_comb begin
    evPulse = '0;
    evPulse[EV_SOF] = sofSeen;
    evPulse[EV_RST_ON] = (line == LINE_SE0) && (stateCount == CW'(RST_MIN_CYC - 1)) && !afterK;
    evPulse[EV_RST_OFF] = longSe0 && (line == LINE_J);
    evPulse[EV_SUSPEND] = (line == LINE_J) && (stateCount == CW'(SUSP_CYCLES - 1));
    evPulse[EV_AWAKE] = afterK && (prevLine == LINE_SE0) && (line != LINE_SE0)
      && (stateCount >= CW'(RESUME_MIN_CYC)) && suspended;
  end

  // ---------------------------------------------------------------
  // power control
  // ---------------------------------------------------------------
  logic [7:0] standbyControlReg;
  logic [7:0] oscillatorTestReg;
  logic forcedDown;

  assign forcedDown = oscillatorTestReg[OSC_TEST_PD_BIT] && !oscillatorTestReg[OSC_TEST_ZERO_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) suspended <= 1'b0;
    else if (evPulse[EV_AWAKE]) suspended <= 1'b0;
    else if (evPulse[EV_SUSPEND]) suspended <= 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) usbOscRun <= 1'b1;
    else if (!suspended) usbOscRun <= 1'b1;
    else if (line == LINE_J && stateCount == CW'(SUSP_CYCLES + OSC_STOP_CYCLES - 1)) usbOscRun <= 1'b0;
  end

  assign powerDown = suspended || forcedDown;
  assign pllEnable = !powerDown;
  assign oscEnable = !(powerDown && standbyControlReg[OSC_STOP_SEL_BIT] && cpuStopOrSub);

  // ---------------------------------------------------------------
  // event flags and interrupt
  // ---------------------------------------------------------------
  logic [EV_NUM-1:0] evStatus;
  logic [EV_NUM-1:0] evEnable;
  logic [EV_NUM-1:0] evClear;

  assign evClear = (regWrite && regAddr == ADDR_EVT_CLEAR) ? regWdata[EV_NUM-1:0] : '0;

  // set wins over clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) evStatus <= '0;
    else evStatus <= (evStatus & ~evClear) | evPulse;
  end

  assign irq = |(evStatus & evEnable);

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  logic [1:0][7:0] dmaCtrl;
  logic [1:0][7:0] dmaIntv;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) evEnable <= '0;
    else if (regWrite && regAddr == ADDR_EVT_ENABLE) evEnable <= regWdata[EV_NUM-1:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      standbyControlReg <= REG_RESET;
      oscillatorTestReg <= REG_RESET;
    end else if (regWrite) begin
      if (regAddr == ADDR_STANDBY) standbyControlReg <= regWdata;
      else if (regAddr == ADDR_OSC_TEST) oscillatorTestReg <= regWdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaCtrl <= '0;
      dmaIntv <= '0;
    end else if (regWrite) begin
      if (regAddr == ADDR_DMA_CTRL0) dmaCtrl[0] <= regWdata;
      else if (regAddr == ADDR_DMA_CTRL1) dmaCtrl[1] <= regWdata;
      else if (regAddr == ADDR_DMA_INTV0) dmaIntv[0] <= regWdata;
      else if (regAddr == ADDR_DMA_INTV1) dmaIntv[1] <= regWdata;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  logic [7:0] next_regRdata;

  always_comb begin
    next_regRdata = '0;
    if (regAddr == ADDR_EVT_STATUS) next_regRdata = 8'(evStatus);
    else if (regAddr == ADDR_EVT_ENABLE) next_regRdata = 8'(evEnable);
    else if (regAddr == ADDR_STANDBY) next_regRdata = standbyControlReg;
    else if (regAddr == ADDR_OSC_TEST) next_regRdata = oscillatorTestReg;
    else if (regAddr == ADDR_DMA_CTRL0) next_regRdata = dmaCtrl[0];
    else if (regAddr == ADDR_DMA_CTRL1) next_regRdata = dmaCtrl[1];
    else if (regAddr == ADDR_DMA_INTV0) next_regRdata = dmaIntv[0];
    else if (regAddr == ADDR_DMA_INTV1) next_regRdata = dmaIntv[1];
    else if (regAddr == ADDR_POWER) next_regRdata = {4'h0, usbOscRun, oscEnable, suspended, powerDown};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) regRdata <= '0;
    else if (regRead) regRdata <= next_regRdata;
    else regRdata <= '0;
  end

  // ---------------------------------------------------------------
  // dma channels
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gDma
      logic [DMA_EP_W-1:0] ep;
      logic epOk;
      assign ep = dmaCtrl[ch][DMA_EP_LSB +: DMA_EP_W];
      // only endpoints 1,2,4,5 may be serviced
      assign epOk = (ep == 3'd1) || (ep == 3'd2) || (ep == 3'd4) || (ep == 3'd5);
      assign dmaEndpoint[ch] = ep;
      ubev_dma_chan #(
        .INTV_W(INTV_W)
      ) uChan (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enable(dmaCtrl[ch][DMA_EN_BIT] && epOk),
        .singleMode(dmaCtrl[ch][DMA_MODE_BIT]),
        .gapCycles(dmaIntv[ch][INTV_W-1:0]),
        .packetReady(epPacketReady[ep]),
        .byteAck(dmaByteAck[ch]),
        .packetDone(dmaPacketDone[ch]),
        .dmaRequestLine(dmaRequestLine[ch])
      );
    end
  endgenerate
endmodule : ubev_bus_events

// *** tb/ubev_bus_events_asserts.sv ***
`timescale 1ns/1ps
module ubev_bus_events_asserts
  import ubev_pkg::*;
#(
  parameter int SUSP_CYCLES = SUSP_CYC,
  parameter int OSC_STOP_CYCLES = OSC_STOP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dPlus,
  input wire logic dMinus,
  input wire logic sofSeen,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic irq,
  input wire logic [1:0] dmaByteAck,
  input wire logic [1:0] dmaPacketDone,
  input wire logic [1:0] dmaRequestLine,
  input wire logic cpuStopOrSub,
  input wire logic pllEnable,
  input wire logic oscEnable,
  input wire logic usbOscRun,
  input wire logic powerDown
);
  logic [7:0] en;
  logic [7:0] ctl0;
  logic [7:0] ctl1;
  logic oscSel;
  logic afterJ;
  int se0Cnt;
  int jCnt;
  wire logic wrClr = regWrite && (regAddr == ADDR_EVT_CLEAR || regAddr == ADDR_EVT_ENABLE);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // shadow of written settings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {en, ctl0, ctl1, oscSel} <= '0;
    end else if (regWrite) begin
      if (regAddr == ADDR_EVT_ENABLE) en <= regWdata;
      if (regAddr == ADDR_DMA_CTRL0) ctl0 <= regWdata;
      if (regAddr == ADDR_DMA_CTRL1) ctl1 <= regWdata;
      if (regAddr == ADDR_STANDBY) oscSel <= regWdata[OSC_STOP_SEL_BIT];
    end
  end
  // run lengths of line states
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      se0Cnt <= 0;
      jCnt <= 0;
      afterJ <= 1'b1;
    end else begin
      se0Cnt <= ({dPlus, dMinus} == LINE_SE0) ? se0Cnt + 1 : 0;
      jCnt <= ({dPlus, dMinus} == LINE_J) ? jCnt + 1 : 0;
      if ({dPlus, dMinus} != LINE_SE0) afterJ <= ({dPlus, dMinus} == LINE_J);
    end
  end
  chk_sof_irq: assert property (sofSeen && en[EV_SOF] |=> irq) else $error("sof gave no irq");
  chk_flag_sticky: assert property (irq && !wrClr |=> irq) else $error("irq dropped");
  chk_reset_seen: assert property (se0Cnt == RST_MIN_CYC + 10 && afterJ && en[EV_RST_ON] |-> irq)
    else $error("long se0 gave no irq");
  chk_suspend_pd: assert property (jCnt == SUSP_CYCLES + 2 |-> powerDown) else $error("no suspend");
  chk_osc_stop: assert property (jCnt == SUSP_CYCLES + OSC_STOP_CYCLES + 3 |-> !usbOscRun)
    else $error("usb osc still runs");
  chk_pll_stop: assert property (powerDown |-> !pllEnable) else $error("pll runs in pd");
  chk_osc_gate: assert property (powerDown && oscSel && cpuStopOrSub |-> !oscEnable) else $error("osc on");
  chk_run_clocks: assert property (!powerDown |-> pllEnable && oscEnable) else $error("clock off");
  chk_demand_hold: assert property (dmaRequestLine[0] && !ctl0[DMA_MODE_BIT] && !dmaPacketDone[0]
    |=> dmaRequestLine[0]) else $error("demand dropped");
  chk_single_drop: assert property (dmaByteAck[1] && dmaRequestLine[1] && ctl1[DMA_MODE_BIT]
    |=> !dmaRequestLine[1]) else $error("single held");
  cov_sof: cover property (sofSeen && en[EV_SOF]);
  cov_wake: cover property ($fell(powerDown));
  cov_single: cover property (dmaByteAck[1] && dmaRequestLine[1]);
endmodule : ubev_bus_events_asserts

bind ubev_bus_events ubev_bus_events_asserts #(.SUSP_CYCLES(SUSP_CYCLES), .OSC_STOP_CYCLES(OSC_STOP_CYCLES)) u_chk (
  .sys_clk, .rst_n, .dPlus, .dMinus, .sofSeen, .regAddr, .regWdata, .regWrite, .irq, .dmaByteAck,
  .dmaPacketDone, .dmaRequestLine, .cpuStopOrSub, .pllEnable, .oscEnable, .usbOscRun, .powerDown);

// *** tb/ubev_host_model.sv ***
`timescale 1ns/1ps
module ubev_host_model
  import ubev_pkg::*;
(
  input wire logic sys_clk,
  output logic dPlus,
  output logic dMinus,
  output logic sofSeen
);
  initial begin
    {dPlus, dMinus} = LINE_J;
    sofSeen = 1'b0;
  end
  task automatic line(input ubev_line_type st, input int cyc);
    {dPlus, dMinus} <= st;
    repeat (cyc) @(posedge sys_clk);
  endtask : line
  task automatic sof();
    sofSeen <= 1'b1;
    @(posedge sys_clk);
    sofSeen <= 1'b0;
    @(posedge sys_clk);
  endtask : sof
endmodule : ubev_host_model

// *** tb/ubev_bus_events_bench.sv ***
`timescale 1ns/1ps
module ubev_bus_events_bench
  import ubev_pkg::*;
;
  localparam int SUSP = 200;
  localparam int OSTOP = 100;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [5:0] epPacketReady = 6'h00;
  logic [1:0] dmaByteAck = 2'h0;
  logic [1:0] dmaPacketDone = 2'h0;
  logic cpuStopOrSub = 1'b0;
  logic dPlus, dMinus, sofSeen, irq, pllEnable, oscEnable, usbOscRun, powerDown;
  logic [7:0] regRdata;
  logic [7:0] got;
  logic [1:0] dmaRequestLine;
  logic [1:0][DMA_EP_W-1:0] dmaEndpoint;
  int errors = 0;
  int checks = 0;
  int model = 0;
  int seed = 32'h148a;
  int eps[$] = '{1, 2, 4, 5};
  always #25 sys_clk = ~sys_clk;
  ubev_bus_events #(.SUSP_CYCLES(SUSP), .OSC_STOP_CYCLES(OSTOP)) u_dut (
    .sys_clk, .rst_n, .dPlus, .dMinus, .sofSeen, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq,
    .epPacketReady, .dmaByteAck, .dmaPacketDone, .dmaRequestLine, .dmaEndpoint, .cpuStopOrSub, .pllEnable,
    .oscEnable, .usbOscRun, .powerDown);
  ubev_host_model u_host (.sys_clk, .dPlus, .dMinus, .sofSeen);
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
    @(posedge sys_clk);
  endtask : rd
  task automatic stat();
    rd(ADDR_EVT_STATUS, got);
    cmp(got, model[7:0]);
    cmp({7'h00, irq}, {7'h00, model[4:0] != 0});
  endtask : stat
  task automatic clr();
    wr(ADDR_EVT_CLEAR, model[7:0]);
    model = 0;
    stat();
  endtask : clr
  task automatic dma(input int ch, input int ep, input logic sgl);
    int n;
    wr(ch ? ADDR_DMA_CTRL1 : ADDR_DMA_CTRL0, {3'b000, ep[2:0], sgl, 1'b1});
    cmp({5'h00, dmaEndpoint[ch]}, ep[7:0]);
    epPacketReady[ep] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp({7'h00, dmaRequestLine[ch]}, 8'h01);
    dmaByteAck[ch] <= 1'b1;
    @(posedge sys_clk);
    dmaByteAck[ch] <= 1'b0;
    @(negedge sys_clk);
    cmp({7'h00, dmaRequestLine[ch]}, {7'h00, !sgl});
    @(posedge sys_clk);
    n = 0;
    while (dmaRequestLine[ch] !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    cmp({7'h00, dmaRequestLine[ch]}, 8'h01);
    dmaPacketDone[ch] <= 1'b1;
    epPacketReady[ep] <= 1'b0;
    @(posedge sys_clk);
    dmaPacketDone[ch] <= 1'b0;
    @(posedge sys_clk);
    cmp({7'h00, dmaRequestLine[ch]}, 8'h00);
  endtask : dma
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    stat();
    rd(ADDR_POWER, got);
    cmp(got, 8'h0c);
    rd(4'hf, got);
    cmp(got, 8'h00);
    wr(ADDR_EVT_ENABLE, 8'h1f);
    $display("test regs done");
    u_host.sof();
    model = model | 1;
    stat();
    clr();
    $display("test sof done");
    u_host.line(LINE_SE0, 30);
    u_host.line(LINE_J, 3);
    stat();
    u_host.line(LINE_SE0, RST_MIN_CYC + 10);
    u_host.line(LINE_J, 3);
    model = model | 6;
    stat();
    clr();
    $display("test reset done");
    wr(ADDR_OSC_TEST, 8'h06);
    cmp({7'h00, powerDown}, 8'h00);
    wr(ADDR_OSC_TEST, 8'h04);
    cmp({7'h00, powerDown}, 8'h01);
    wr(ADDR_OSC_TEST, 8'h00);
    foreach (eps[i]) dma(0, eps[i], 1'b0);
    wr(ADDR_DMA_INTV1, 8'($random(seed) & 7));
    dma(1, 2, 1'b1);
    $display("test dma done");
    wr(ADDR_STANDBY, 8'h08);
    cpuStopOrSub <= 1'b1;
    u_host.line(LINE_J, SUSP + OSTOP + 10);
    model = model | 8;
    stat();
    rd(ADDR_POWER, got);
    cmp(got, 8'h03);
    u_host.line(LINE_K, 20);
    u_host.line(LINE_SE0, 20);
    u_host.line(LINE_J, 3);
    model = model | 16;
    stat();
    rd(ADDR_POWER, got);
    cmp(got, 8'h0c);
    clr();
    $display("test suspend done");
    close_out();
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    errors++;
    close_out();
  end
endmodule : ubev_bus_events_bench
